// File: mps_derate.sv
/*
 linear duty limiter: full duty below start, falling with excess above it.
 assumes start below the trip level; excess is scaled by a shift.
*/
`timescale 1ns/10ps
module mps_derate #(
    parameter int W     = 16,
    parameter int SHIFT = 2
) (
    input  wire logic [W-1:0] value,  // measured quantity
    input  wire logic [W-1:0] start,  // limiting starts here
    output logic [W-1:0]      cap,    // allowed duty
    output logic              active  // limiting in force
);
    logic [W-1:0] excess;
    logic [W:0]   scaled;
    initial begin
        if (SHIFT < 0 || SHIFT >= W) $error("mps_derate: bad SHIFT");
    end
    assign active = value > start;
    assign excess = active ? value - start : '0;
    assign scaled = {1'b0, excess} << SHIFT;
    assign cap    = scaled[W] ? '0 : ~scaled[W-1:0];
endmodule : mps_derate

// File: mps_host_model.sv
/* host command source: a valid command strobe every PERIOD cycles.
 assumes enable is a level from the bench. */
`timescale 1ns/10ps
module mps_host_model #(
    parameter int PERIOD = 10 // cycles between commands
) (
    input  wire logic clock,   // system clock
    input  wire logic srst,    // sync reset
    input  wire logic enable,  // host link alive
    output logic      cmdValid // command strobe
);
    int cnt;
    // dropping enable models a lost link, which the timeout must catch
    always_ff @(posedge clock) begin
        cnt      <= (srst || !enable || cnt == PERIOD - 1) ? 0 : cnt + 1;
        cmdValid <= !srst && enable && cnt == PERIOD - 1;
    end
endmodule : mps_host_model

// File: mps_pkg.sv
/*
 shared constants and types of the protection supervisor.
 assumes a 32-bit APB register bus with word-aligned registers.
*/
package mps_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04; // read only
    localparam logic [7:0] OFS_IRQST   = 8'h08; // clear on read
    localparam logic [7:0] OFS_IRQMSK  = 8'h0C;
    localparam logic [7:0] OFS_ILIM    = 8'h10;
    localparam logic [7:0] OFS_TLIM    = 8'h14;
    localparam logic [7:0] OFS_TDER    = 8'h18;
    localparam logic [7:0] OFS_WMAX    = 8'h1C;
    localparam logic [7:0] OFS_WEXT    = 8'h20;
    localparam logic [7:0] OFS_VBMAX   = 8'h24;
    localparam logic [7:0] OFS_TMO     = 8'h28;
    localparam logic [7:0] OFS_WDT     = 8'h2C;
    localparam logic [7:0] OFS_KICK    = 8'h30;

    // ----------------------------------------------------------------
    // control bits
    // ----------------------------------------------------------------
    localparam int CTRL_ARM      = 0;
    localparam int CTRL_ILATCH   = 1;
    localparam int CTRL_TLATCH   = 2;
    localparam int CTRL_ICLR     = 3; // self-clearing
    localparam int CTRL_TCLR     = 4; // self-clearing

    // ----------------------------------------------------------------
    // event / status bit positions
    // ----------------------------------------------------------------
    localparam int EV_ITRIP   = 0;
    localparam int EV_TTRIP   = 1;
    localparam int EV_DERATE  = 2;
    localparam int EV_OVSPD   = 3;
    localparam int EV_BRAKE   = 4;
    localparam int EV_REGEN   = 5;
    localparam int EV_TMO     = 6;
    localparam int EV_WDT     = 7;
    localparam int EV_NUM     = 8;

    localparam int ST_ARMED   = 8;
    localparam int ST_IFLAG   = 9;
    localparam int ST_TFLAG   = 10;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_ILIM  = 16'hC000;
    localparam logic [15:0] RST_TLIM  = 16'hF000;
    localparam logic [15:0] RST_TDER  = 16'hD000;
    localparam logic [15:0] RST_WMAX  = 16'hC000;
    localparam logic [15:0] RST_WEXT  = 16'hE000;
    localparam logic [15:0] RST_VBMAX = 16'hE000;
    localparam logic [31:0] RST_TMO   = 32'h0000_C350; // 1 ms at 50 MHz
    localparam logic [31:0] RST_WDT   = 32'h0007_A120; // 10 ms at 50 MHz
    localparam logic [15:0] DUTY_FULL = 16'hFFFF;

    // ----------------------------------------------------------------
    // bridge drive mode
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MPS_DRIVE = 2'b00, // normal switching
        MPS_OFF   = 2'b01, // all transistors off
        MPS_COAST = 2'b10, // disarmed, freewheel
        MPS_BRAKE = 2'b11  // phases shorted together
    } mps_mode_t;
endpackage : mps_pkg

// File: mps_supervisor.sv
/*
 motor protection supervisor top: limits duty, trips, brake, timeout, watchdog, APB registers.
 assumes measurements and command strobe come from logic on clock; can pads are pins.
*/
// Chosen here: register access over APB and the placing of the registers.
// Summary of operation
// - duty capped so predicted current stays under the limit
// - overcurrent turns every bridge transistor off at once
// - current trip may latch until host clears its flag
// - unlatched current trip releases below threshold
// - near maximum temperature duty derates, keeping most power
// - derate ends by itself as temperature falls
// - estimated coil temperature derates the same way
// - overtemperature turns all transistors off, latch optional
// - unlatched thermal trip releases below threshold
// - above maximum speed duty falls with the excess
// - extreme overspeed shorts all phases as a brake
// - regenerated bus overvoltage limits duty
// - no valid command within timeout disarms and coasts
// - a new valid command after timeout clears it; drive resumes once the host sets arm again
// - watchdog expiry reboots with the motor unarmed
// - both can pad pairs share one can peripheral
`timescale 1ns/10ps
module mps_supervisor #(
    parameter int W     = 16,       // measurement width
    parameter int SHIFT = 2         // derate slope
) (
    input  wire logic         clock,      // 50 MHz system clock
    input  wire logic         srst,       // synchronous reset, active high
    input  wire logic         psel,       // apb select
    input  wire logic         penable,    // apb enable
    input  wire logic         pwrite,     // apb direction
    input  wire logic [7:0]   paddr,      // apb byte address
    input  wire logic [31:0]  pwdata,     // apb write data
    output logic [31:0]       prdata,     // apb read data
    output logic              pready,     // apb ready
    output logic              pslverr,    // apb error
    input  wire logic [W-1:0] phaseCur,   // measured phase current
    input  wire logic [W-1:0] predCur,    // predicted current at full duty
    input  wire logic [W-1:0] escTemp,    // controller temperature
    input  wire logic [W-1:0] coilTemp,   // modelled coil temperature
    input  wire logic [W-1:0] rotorSpeed, // speed magnitude
    input  wire logic [W-1:0] busVolt,    // supply voltage
    input  wire logic [W-1:0] dutyReq,    // duty from the speed loop
    input  wire logic         cmdValid,   // valid host command strobe
    input  wire logic         canRxA,     // can pad pair a receive
    input  wire logic         canRxB,     // can pad pair b receive
    input  wire logic         canTx,      // can peripheral transmit
    output logic              canRx,      // combined peripheral receive
    output logic              canTxA,     // pad pair a transmit
    output logic              canTxB,     // pad pair b transmit
    output logic [W-1:0]      dutyOut,    // limited duty
    output logic [1:0]        bridgeMode, // mps_mode_t drive mode
    output logic              rebootReq,  // watchdog reboot pulse
    output logic              irq         // level interrupt
);
    initial begin
        if (W < 8 || W > 16) $error("mps_supervisor: W must be 8..16");
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [2:0]        ctrl_r;
    logic [mps_pkg::EV_NUM-1:0] irqSt_r, irqSt_nxt, irqMsk_r;
    logic [W-1:0]      iLim_r, tLim_r, tDer_r, wMax_r, wExt_r, vbMax_r;
    logic [31:0]       tmo_r, wdt_r, tmoCnt_r, wdtCnt_r;
    logic              timedOut_r, wdtKick_r;
    logic [31:0]       prdata_r, rdMux;
    logic              pready_r, pslverr_r;
    logic [W-1:0]      duty_r;
    mps_pkg::mps_mode_t mode_r, mode_nxt;
    logic              reboot_r, irq_r;
    logic              canA1_r, canA2_r, canB1_r, canB2_r, canRx_r, canTxA_r;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire setup   = psel && !penable;
    wire wrStb   = psel && penable && pwrite && pready_r;
    wire rdStb   = psel && penable && !pwrite && pready_r;
    wire hitCtrl = paddr == mps_pkg::OFS_CTRL;
    wire hitSt   = paddr == mps_pkg::OFS_STATUS;
    wire hitIrq  = paddr == mps_pkg::OFS_IRQST;
    wire hitMsk  = paddr == mps_pkg::OFS_IRQMSK;
    wire hitIlim = paddr == mps_pkg::OFS_ILIM;
    wire hitTlim = paddr == mps_pkg::OFS_TLIM;
    wire hitTder = paddr == mps_pkg::OFS_TDER;
    wire hitWmax = paddr == mps_pkg::OFS_WMAX;
    wire hitWext = paddr == mps_pkg::OFS_WEXT;
    wire hitVb   = paddr == mps_pkg::OFS_VBMAX;
    wire hitTmo  = paddr == mps_pkg::OFS_TMO;
    wire hitWdt  = paddr == mps_pkg::OFS_WDT;
    wire hitKick = paddr == mps_pkg::OFS_KICK;
    wire mapped  = hitCtrl | hitSt | hitIrq | hitMsk | hitIlim | hitTlim | hitTder
                 | hitWmax | hitWext | hitVb | hitTmo | hitWdt | hitKick;
    wire iClr    = wrStb && hitCtrl && pwdata[mps_pkg::CTRL_ICLR];
    wire tClr    = wrStb && hitCtrl && pwdata[mps_pkg::CTRL_TCLR];
    wire armed   = ctrl_r[mps_pkg::CTRL_ARM];

    // ----------------------------------------------------------------
    // trips
    // ----------------------------------------------------------------
    logic iTrip, iFlag, iOnset, tTripE, tFlagE, tOnsE, tTripC, tFlagC, tOnsC;
    logic [W-1:0] tempMax;
    assign tempMax = (escTemp > coilTemp) ? escTemp : coilTemp;

    mps_trip #(.W(W)) uCurTrip (
        .clock(clock), .srst(srst), .value(phaseCur), .limit(iLim_r),
        .latchMode(ctrl_r[mps_pkg::CTRL_ILATCH]), .clearReq(iClr),
        .tripped(iTrip), .flag(iFlag), .onset(iOnset)
    );
    mps_trip #(.W(W)) uEscTrip (
        .clock(clock), .srst(srst), .value(escTemp), .limit(tLim_r),
        .latchMode(ctrl_r[mps_pkg::CTRL_TLATCH]), .clearReq(tClr),
        .tripped(tTripE), .flag(tFlagE), .onset(tOnsE)
    );
    mps_trip #(.W(W)) uCoilTrip (
        .clock(clock), .srst(srst), .value(coilTemp), .limit(tLim_r),
        .latchMode(ctrl_r[mps_pkg::CTRL_TLATCH]), .clearReq(tClr),
        .tripped(tTripC), .flag(tFlagC), .onset(tOnsC)
    );
    wire tTrip  = tTripE | tTripC;
    wire tFlag  = tFlagE | tFlagC;
    wire tOnset = tOnsE | tOnsC;

    // ----------------------------------------------------------------
    // duty limiters
    // ----------------------------------------------------------------
    logic [W-1:0] capTemp, capSpeed, capRegen, capCur;
    logic derating, overSpeed, regenLim, iPred;
    mps_derate #(.W(W), .SHIFT(SHIFT)) uTempDer (
        .value(tempMax), .start(tDer_r), .cap(capTemp), .active(derating)
    );
    mps_derate #(.W(W), .SHIFT(SHIFT)) uSpeedLim (
        .value(rotorSpeed), .start(wMax_r), .cap(capSpeed), .active(overSpeed)
    );
    mps_derate #(.W(W), .SHIFT(SHIFT)) uRegenLim (
        .value(busVolt), .start(vbMax_r), .cap(capRegen), .active(regenLim)
    );
    // current scales with duty: cap at ilim/pred of full scale
    logic [2*W-1:0] curScaled;
    assign iPred     = predCur > iLim_r;
    assign curScaled = {iLim_r, {W{1'b0}}} / {{W{1'b0}}, (predCur == '0 ? {{(W-1){1'b0}},1'b1}
                                                               : predCur)};
    assign capCur    = iPred ? curScaled[W-1:0] : {W{1'b1}};
    wire extreme     = rotorSpeed >= wExt_r;

    logic [W-1:0] m1, m2, m3, dutyLim;
    assign m1      = (dutyReq < capCur) ? dutyReq : capCur;
    assign m2      = (m1 < capTemp) ? m1 : capTemp;
    assign m3      = (m2 < capSpeed) ? m2 : capSpeed;
    assign dutyLim = (m3 < capRegen) ? m3 : capRegen;

    // ----------------------------------------------------------------
    // bridge mode: off beats brake beats coast
    // ----------------------------------------------------------------
    always_comb begin
        if (iTrip || tTrip)
            mode_nxt = mps_pkg::MPS_OFF;
        else if (extreme)
            mode_nxt = mps_pkg::MPS_BRAKE;
        else if (!armed || timedOut_r)
            mode_nxt = mps_pkg::MPS_COAST;
        else
            mode_nxt = mps_pkg::MPS_DRIVE;
    end
    wire driving = mode_nxt == mps_pkg::MPS_DRIVE;

    // ----------------------------------------------------------------
    // command timeout and watchdog
    // ----------------------------------------------------------------
    wire tmoHit = !timedOut_r && (tmoCnt_r >= tmo_r);
    wire wdtHit = wdtCnt_r >= wdt_r;

    // counter holds after a timeout: one event per loss
    always_ff @(posedge clock) begin
        if (srst || cmdValid)
            tmoCnt_r <= '0;
        else if (!timedOut_r)
            tmoCnt_r <= tmoCnt_r + 32'h1;
    end
    always_ff @(posedge clock) begin
        if (srst)
            timedOut_r <= 1'b0;
        else if (cmdValid)
            timedOut_r <= 1'b0;
        else if (tmoHit)
            timedOut_r <= 1'b1;
    end
    always_ff @(posedge clock) begin
        if (srst || wdtKick_r || wdtHit)
            wdtCnt_r <= '0;
        else
            wdtCnt_r <= wdtCnt_r + 32'h1;
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            wdtKick_r <= 1'b0;
            reboot_r  <= 1'b0;
        end else begin
            wdtKick_r <= wrStb && hitKick;
            reboot_r  <= wdtHit;
        end
    end

    // ----------------------------------------------------------------
    // control and limit registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst || wdtHit)
            ctrl_r <= '0;
        else if (tmoHit)
            ctrl_r[mps_pkg::CTRL_ARM] <= 1'b0;
        else if (wrStb && hitCtrl)
            ctrl_r <= pwdata[2:0];
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            iLim_r  <= mps_pkg::RST_ILIM[W-1:0];
            tLim_r  <= mps_pkg::RST_TLIM[W-1:0];
            tDer_r  <= mps_pkg::RST_TDER[W-1:0];
            wMax_r  <= mps_pkg::RST_WMAX[W-1:0];
            wExt_r  <= mps_pkg::RST_WEXT[W-1:0];
            vbMax_r <= mps_pkg::RST_VBMAX[W-1:0];
            tmo_r   <= mps_pkg::RST_TMO;
            wdt_r   <= mps_pkg::RST_WDT;
            irqMsk_r <= '0;
        end else if (wrStb) begin
            if (hitIlim) iLim_r  <= pwdata[W-1:0];
            if (hitTlim) tLim_r  <= pwdata[W-1:0];
            if (hitTder) tDer_r  <= pwdata[W-1:0];
            if (hitWmax) wMax_r  <= pwdata[W-1:0];
            if (hitWext) wExt_r  <= pwdata[W-1:0];
            if (hitVb)   vbMax_r <= pwdata[W-1:0];
            if (hitTmo)  tmo_r   <= pwdata;
            if (hitWdt)  wdt_r   <= pwdata;
            if (hitMsk)  irqMsk_r <= pwdata[mps_pkg::EV_NUM-1:0];
        end
    end

    // ----------------------------------------------------------------
    // interrupt status: new events win over the read clear
    // ----------------------------------------------------------------
    logic [mps_pkg::EV_NUM-1:0] events;
    assign events = {wdtHit, tmoHit, regenLim, extreme,
                     overSpeed, derating, tOnset, iOnset};
    assign irqSt_nxt = ((rdStb && hitIrq) ? '0 : irqSt_r) | events;
    always_ff @(posedge clock) begin
        if (srst) begin
            irqSt_r <= '0;
            irq_r   <= 1'b0;
        end else begin
            irqSt_r <= irqSt_nxt;
            irq_r   <= |(irqSt_nxt & irqMsk_r);
        end
    end

    // ----------------------------------------------------------------
    // apb read path; ready registered from the setup phase, so every access completes with no wait state
    // ----------------------------------------------------------------
    logic [31:0] statusWord;
    assign statusWord = {21'h0, tFlag, iFlag, armed,
                         timedOut_r, extreme, regenLim, overSpeed, derating,
                         mode_r, tTrip | iTrip};
    always_comb begin
        rdMux = 32'h0;
        if (hitCtrl) rdMux = {29'h0, ctrl_r};
        if (hitSt)   rdMux = {statusWord[31:11], tFlag, iFlag, armed, statusWord[7:0]};
        if (hitIrq)  rdMux = {24'h0, irqSt_r};
        if (hitMsk)  rdMux = {24'h0, irqMsk_r};
        if (hitIlim) rdMux = {{(32-W){1'b0}}, iLim_r};
        if (hitTlim) rdMux = {{(32-W){1'b0}}, tLim_r};
        if (hitTder) rdMux = {{(32-W){1'b0}}, tDer_r};
        if (hitWmax) rdMux = {{(32-W){1'b0}}, wMax_r};
        if (hitWext) rdMux = {{(32-W){1'b0}}, wExt_r};
        if (hitVb)   rdMux = {{(32-W){1'b0}}, vbMax_r};
        if (hitTmo)  rdMux = tmo_r;
        if (hitWdt)  rdMux = wdt_r;
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup && !mapped;
            prdata_r  <= (setup && !pwrite) ? rdMux : 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // output stage and can pass-through
    // ----------------------------------------------------------------
    // duty is zeroed outside drive so a stale value never leaks
    always_ff @(posedge clock) begin
        if (srst) begin
            duty_r <= '0;
            mode_r <= mps_pkg::MPS_COAST;
        end else begin
            duty_r <= driving ? dutyLim : '0;
            mode_r <= mode_nxt;
        end
    end
    // both pad pairs share one peripheral; dominant low on either pair is seen
    always_ff @(posedge clock) begin
        if (srst) begin
            canA1_r  <= 1'b1;
            canA2_r  <= 1'b1;
            canB1_r  <= 1'b1;
            canB2_r  <= 1'b1;
            canRx_r  <= 1'b1;
            canTxA_r <= 1'b1;
        end else begin
            canA1_r  <= canRxA;
            canA2_r  <= canA1_r;
            canB1_r  <= canRxB;
            canB2_r  <= canB1_r;
            canRx_r  <= canA2_r & canB2_r;
            canTxA_r <= canTx;
        end
    end

    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign dutyOut    = duty_r;
    assign bridgeMode = mode_r;
    assign rebootReq  = reboot_r;
    assign irq        = irq_r;
    assign canRx      = canRx_r;
    assign canTxA     = canTxA_r;
    assign canTxB     = canTxA_r;
endmodule : mps_supervisor

// File: mps_supervisor_props.sv
/* checker for mps_supervisor: protection relations seen at the ports.
 assumes the threshold registers keep their reset values. */
`timescale 1ns/10ps
module mps_supervisor_props #(
    parameter int W = 16 // measurement width
) (
    input wire logic         clock,      // system clock
    input wire logic         srst,       // sync reset
    input wire logic [W-1:0] phaseCur,   // current
    input wire logic [W-1:0] predCur,    // predicted current
    input wire logic [W-1:0] escTemp,    // controller temp
    input wire logic [W-1:0] coilTemp,   // coil estimate
    input wire logic [W-1:0] rotorSpeed, // speed
    input wire logic [W-1:0] busVolt,    // supply
    input wire logic [W-1:0] dutyReq,    // requested duty
    input wire logic [W-1:0] dutyOut,    // limited duty
    input wire logic [1:0]   bridgeMode, // drive mode
    input wire logic         rebootReq   // watchdog pulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // calm inputs: duty passes untouched
    sequence calm;
        phaseCur < mps_pkg::RST_ILIM && predCur <= mps_pkg::RST_ILIM
        && escTemp <= mps_pkg::RST_TDER && coilTemp <= mps_pkg::RST_TDER
        && rotorSpeed < mps_pkg::RST_WMAX && busVolt <= mps_pkg::RST_VBMAX && $stable(dutyReq);
    endsequence
    sequence fullAsk(c);
        (c && dutyReq == mps_pkg::DUTY_FULL)[*3] ##0 bridgeMode == mps_pkg::MPS_DRIVE;
    endsequence
    property capped(c);
        fullAsk(c) |-> dutyOut != mps_pkg::DUTY_FULL;
    endproperty
    AST_ITRIP: assert property ((phaseCur >= mps_pkg::RST_ILIM)[*3]
        |-> bridgeMode == mps_pkg::MPS_OFF) else $error("no current trip");
    AST_TTRIP: assert property ((escTemp >= mps_pkg::RST_TLIM)[*3]
        |-> bridgeMode == mps_pkg::MPS_OFF) else $error("no thermal trip");
    AST_DOFF: assert property (bridgeMode != mps_pkg::MPS_DRIVE |-> dutyOut == '0)
        else $error("duty not off");
    AST_BRAKE: assert property ((rotorSpeed >= mps_pkg::RST_WEXT
        && phaseCur < mps_pkg::RST_ILIM && escTemp < mps_pkg::RST_TLIM
        && coilTemp < mps_pkg::RST_TLIM)[*3] |-> bridgeMode == mps_pkg::MPS_BRAKE)
        else $error("no brake");
    AST_DERATE: assert property (capped(escTemp > mps_pkg::RST_TDER))
        else $error("no esc derate");
    AST_COIL: assert property (capped(coilTemp > mps_pkg::RST_TDER))
        else $error("no coil derate");
    AST_OVSPD: assert property (capped(rotorSpeed > mps_pkg::RST_WMAX))
        else $error("no speed limit");
    AST_REGEN: assert property (capped(busVolt > mps_pkg::RST_VBMAX))
        else $error("no regen limit");
    AST_CALM: assert property (calm[*3] ##0 bridgeMode == mps_pkg::MPS_DRIVE
        |-> dutyOut == dutyReq) else $error("duty limited");
    AST_WDOG: assert property (rebootReq |-> ##[1:2] bridgeMode != mps_pkg::MPS_DRIVE)
        else $error("driving after reboot");
endmodule : mps_supervisor_props

bind mps_supervisor mps_supervisor_props #(.W(W)) props_i (.*);

// File: mps_supervisor_tb.sv
/* bench for mps_supervisor: apb tasks, host model, checks.
 assumes reset thresholds; timeouts shortened by writes. */
`timescale 1ns/10ps
module mps_supervisor_tb;
    logic        clock, srst, psel, penable, pwrite, pready, pslverr, pe, irq, hostOn;
    logic        rebootReq, cmdValid, canRxA, canRxB, canTx, canRx, canTxA, canTxB;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] phaseCur, predCur, escTemp, coilTemp, rotorSpeed, busVolt, dutyReq, dutyOut, sv;
    logic [1:0]  bridgeMode;
    int          miscompares, checksDone;

    mps_supervisor DUT (.*);
    mps_host_model HOST (.clock(clock), .srst(srst), .enable(hostOn), .cmdValid(cmdValid));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic chk(input logic [31:0] g, e);
        checksDone++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask : step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd      = prdata;
        pe      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic trip(input logic t, input logic on);
        if (t) escTemp <= on ? 16'hF000 : 16'h0000;
        else phaseCur <= on ? 16'hC000 : 16'h1000;
    endtask : trip
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #300us;
        miscompares++;
        report_and_stop();
    end

    initial begin
        {psel, penable, pwrite, hostOn, srst, canRxA, canRxB, canTx} = 8'h1F;
        {paddr, pwdata, phaseCur, predCur, escTemp, coilTemp} = '0;
        {rotorSpeed, busVolt, miscompares, checksDone} = '0;
        dutyReq = 16'h8000;
        step(20);
        srst <= 1'b0;
        apb(0, mps_pkg::OFS_ILIM, 32'h0);
        chk(rd, 32'h0000_C000);
        apb(0, mps_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(0, 8'h3C, 32'h0);
        chk({pe, rd[30:0]}, {1'b1, 31'h0});
        apb(1, mps_pkg::OFS_TMO, 32'd40);
        hostOn <= 1'b1;
        // k[0] picks the thermal channel, k[1] latching
        for (int k = 0; k < 4; k++) begin
            apb(1, mps_pkg::OFS_CTRL, 32'h1 | (32'(k[1]) << (k[0] + 1)));
            trip(k[0], 1'b1);
            step(4);
            chk({bridgeMode, dutyOut}, {mps_pkg::MPS_OFF, 16'h0});
            trip(k[0], 1'b0);
            step(8);
            chk(bridgeMode, k[1] ? mps_pkg::MPS_OFF : mps_pkg::MPS_DRIVE);
            apb(0, mps_pkg::OFS_STATUS, 32'h0);
            chk(rd[10:9], 2'b01 << k[0]);
            apb(1, mps_pkg::OFS_CTRL, 32'h1 | (32'h8 << k[0]));
            step(3);
            chk(bridgeMode, mps_pkg::MPS_DRIVE);
        end
        chk({irq, dutyOut}, {1'b0, 16'h8000});
        apb(1, mps_pkg::OFS_IRQMSK, 32'h3);
        step(2);
        chk(irq, 1'b1);
        apb(0, mps_pkg::OFS_IRQST, 32'h0);
        chk(rd & 32'h3, 32'h3);
        step(2);
        chk(irq, 1'b0);
        dutyReq <= 16'hFFFF;
        escTemp <= 16'hE000;
        step(4);
        chk(dutyOut, 16'hBFFF);
        escTemp  <= 16'h0;
        coilTemp <= 16'hE000;
        step(4);
        chk(dutyOut, 16'hBFFF);
        coilTemp <= 16'h0;
        predCur  <= 16'hFFFF;
        step(4);
        chk(dutyOut, 16'hC000);
        predCur <= 16'h0;
        busVolt <= 16'hF000;
        step(4);
        chk(dutyOut < 16'hFFFF, 1'b1);
        busVolt    <= 16'h0;
        rotorSpeed <= 16'hC400;
        step(4);
        sv = dutyOut;
        rotorSpeed <= 16'hD000;
        step(4);
        chk(dutyOut < sv && sv < 16'hFFFF, 1'b1);
        rotorSpeed <= 16'hE000;
        step(4);
        chk(bridgeMode, mps_pkg::MPS_BRAKE);
        rotorSpeed <= 16'h0;
        hostOn     <= 1'b0;
        step(50);
        chk(bridgeMode, mps_pkg::MPS_COAST);
        hostOn <= 1'b1;
        apb(1, mps_pkg::OFS_CTRL, 32'h1);
        step(12);
        chk({bridgeMode, dutyOut}, {mps_pkg::MPS_DRIVE, 16'hFFFF});
        apb(1, mps_pkg::OFS_KICK, 32'h0);
        apb(1, mps_pkg::OFS_WDT, 32'd100);
        for (int i = 0; i < 200 && rebootReq !== 1'b1; i++) @(posedge clock);
        chk(rebootReq, 1'b1);
        step(3);
        chk(bridgeMode, mps_pkg::MPS_COAST);
        apb(1, mps_pkg::OFS_WDT, 32'h0010_0000);
        apb(1, mps_pkg::OFS_KICK, 32'h0);
        apb(1, mps_pkg::OFS_CTRL, 32'h1);
        step(12);
        chk(bridgeMode, mps_pkg::MPS_DRIVE);
        canRxA <= 1'b0;
        canTx  <= 1'b0;
        step(5);
        chk({canRx, canTxA, canTxB}, 3'b000);
        report_and_stop();
    end
endmodule : mps_supervisor_tb

// File: mps_trip.sv
/*
 one reactive trip channel with latching or self-releasing behaviour.
 assumes measurements synchronous to clock.
*/
`timescale 1ns/10ps
module mps_trip #(
    parameter int W = 16
) (
    input  wire logic         clock,     // system clock
    input  wire logic         srst,      // synchronous reset
    input  wire logic [W-1:0] value,     // measured quantity
    input  wire logic [W-1:0] limit,     // trip threshold
    input  wire logic         latchMode, // 1 latches trip
    input  wire logic         clearReq,  // host clear pulse
    output logic              tripped,   // outputs must be off
    output logic              flag,      // sticky host flag
    output logic              onset      // pulse at new overlimit
);
    logic over;
    logic overQ_r;
    logic flag_r;
    logic latched_r;
    assign over = value >= limit;

    always_ff @(posedge clock) begin
        if (srst) begin
            overQ_r   <= 1'b0;
            flag_r    <= 1'b0;
            latched_r <= 1'b0;
        end else begin
            overQ_r <= over;
            // a new trip wins over a clear in the same cycle
            if (over)
                flag_r <= 1'b1;
            else if (clearReq)
                flag_r <= 1'b0;
            if (over && latchMode)
                latched_r <= 1'b1;
            else if (clearReq)
                latched_r <= 1'b0;
        end
    end

    assign tripped = over || latched_r;
    assign flag    = flag_r;
    assign onset   = over && !overQ_r;
endmodule : mps_trip
